// ===== cii_intake.v
// interrupt intake, prioritisation and exception entry for the core
//
// Behaviour
// - 24 maskable request lines, each with its own vector.
// - four programmable levels; more urgent pending request preempts a handler.
// - exception entry takes at least 16 clock cycles from the request.
// - non-maskable input, never gated by enables, served apart.
// - taking a request presents the handler address from the vector table.
// - three states: thread, entry and handler; every exception enters handler.
// - line 0 is the radio wake-up from extended sleep.
// - fine target timer event on expiry, counted in 625 us base ticks.
// - gross target timer event on expiry, resolution sixteen base ticks.
// - base tick event every base period, only while radio is active.
// - sleep-end event when the radio leaves sleep.
// - error event on radio misbehaviour or bad programming.
// - receive event at the end of each received packet.
// - event-end event at close of advertising, scanning or connection events.
// - cipher event when block cipher or counter-with-mac job ends.
// - software event raised only on an explicit software request.
// - 24-bit system tick timer with its own exception on expiry.
// - wake-up detector stays active during sleep and wakes on pending sources.
// - supervisor call exception and pendable service exception.
// - faults raise a dedicated fault exception.
`include "cii_defines.vh"

module cii_intake #(
  parameter BASE_TICK_CYC = `CII_BASE_TICK_NS / `CII_CLK_PERIOD_NS
) (
  input  wire                       clk,
  input  wire                       rst,
  input  wire [`CII_NUM_IRQ-3:0]    periph_irq,
  input  wire [`CII_NUM_IRQ-1:0]    irq_enable,
  input  wire                       nmi_req,
  input  wire                       prio_wr,
  input  wire [4:0]                 prio_idx,
  input  wire [`CII_PRIO_W-1:0]     prio_val,
  input  wire                       svc_req,
  input  wire                       pendable_service_exception_set,
  input  wire                       fault_req,
  input  wire                       exc_return,
  input  wire [31:0]                vtor_base,
  input  wire                       sleep_enter,
  input  wire                       systick_en,
  input  wire [`CII_SYSTICK_W-1:0]  systick_reload,
  input  wire                       radio_active,
  input  wire                       radio_wake_evt,
  input  wire                       sleep_end_in,
  input  wire                       radio_error_in,
  input  wire                       packet_rx_in,
  input  wire                       event_end_in,
  input  wire                       cipher_in,
  input  wire                       sw_evt_req,
  input  wire                       fine_arm,
  input  wire [`CII_RTIME_W-1:0]    fine_target,
  input  wire                       gross_arm,
  input  wire [`CII_RTIME_W-5:0]    gross_target,
  input  wire [`CII_RSRC_NUM-1:0]   radio_flag_clr,
  output reg                        handler_mode,
  output reg                        exc_take,
  output reg  [5:0]                 exc_num,
  output reg  [31:0]                vec_addr,
  output reg  [2:0]                 active_level,
  output reg                        core_asleep,
  output reg                        wake_pulse,
  output wire [`CII_RSRC_NUM-1:0]   radio_flags,
  output reg  [`CII_RTIME_W-1:0]    radio_time,
  output reg  [`CII_SYSTICK_W-1:0]  systick_val
);

  // one-hot states
  localparam [2:0] ST_THREAD  = 3'h1;
  localparam [2:0] ST_ENTRY   = 3'h2;
  localparam [2:0] ST_HANDLER = 3'h4;

  // urgency of a candidate slot
  function [2:0] cii_level;
    input [4:0]             idx;
    input [`CII_PRIO_W-1:0] p;
    begin
      if (idx == `CII_CAND_NMI)
        cii_level = `CII_LVL_NMI;
      else if (idx == `CII_CAND_FAULT)
        cii_level = `CII_LVL_FAULT;
      else
        cii_level = {1'b0, p} + `CII_LVL_PROG_BASE;
    end
  endfunction

  // exception number of a candidate slot
  function [5:0] cii_excnum;
    input [4:0] idx;
    begin
      case (idx)
        `CII_CAND_SVC:     cii_excnum = `CII_EXC_SVC;
        `CII_CAND_PENDABLE_SERVICE_EXCEPTION:  cii_excnum = `CII_EXC_PENDABLE_SERVICE_EXCEPTION;
        `CII_CAND_SYSTICK: cii_excnum = `CII_EXC_SYSTICK;
        `CII_CAND_FAULT:   cii_excnum = `CII_EXC_FAULT;
        `CII_CAND_NMI:     cii_excnum = `CII_EXC_NMI;
        default:           cii_excnum = `CII_EXC_IRQ_BASE + {1'b0, idx};
      endcase
    end
  endfunction

  // arbitration, sequencing and timer state
  reg  [2:0]                 state;
  reg  [`CII_NUM_CAND-1:0]   pend;
  reg  [`CII_PRIO_W-1:0]     prio [0:`CII_NUM_CAND-1];
  reg  [2:0]                 stk [0:`CII_STACK_DEPTH-1];
  reg  [2:0]                 sp;
  reg  [4:0]                 win_idx;
  reg  [2:0]                 win_lvl;
  reg  [4:0]                 entry_cnt;
  reg  [`CII_TICKDIV_W-1:0]  tick_div;
  reg                        base_tick;
  reg  [4:0]                 best_idx;
  reg  [2:0]                 best_lvl;
  reg                        best_hit;
  reg  [`CII_NUM_CAND-1:0]   take_clr;
  reg  [`CII_NUM_CAND-1:0]   next_pend;
  // combinational nets
  wire [2:0]                 cand_lvl [0:`CII_NUM_CAND-1];
  wire [`CII_NUM_IRQ-1:0]    lines;
  wire [`CII_NUM_CAND-1:0]   pend_set;
  wire [`CII_RSRC_NUM-1:0]   rsrc;
  wire                       gen_line;
  wire [2:0]                 cur_lvl;
  wire [2:0]                 top_i;
  wire                       st_fire;
  wire                       start_entry;
  wire                       entry_done;
  integer                    i; // arbitration scan only
  integer                    j; // level table reset only
  integer                    k; // stack reset only

  // radio general sources
  assign rsrc[`CII_RSRC_FINE]   = base_tick & fine_arm
                                & (radio_time == fine_target);
  assign rsrc[`CII_RSRC_GROSS]  = base_tick & gross_arm
                                & (radio_time[`CII_GROSS_SHIFT-1:0] == 4'h0)
                                & (radio_time[`CII_RTIME_W-1:`CII_GROSS_SHIFT]
                                   == gross_target);
  assign rsrc[`CII_RSRC_TICK]   = base_tick & radio_active;
  assign rsrc[`CII_RSRC_SLEEP]  = sleep_end_in;
  assign rsrc[`CII_RSRC_ERROR]  = radio_error_in;
  assign rsrc[`CII_RSRC_RX]     = packet_rx_in;
  assign rsrc[`CII_RSRC_EVTEND] = event_end_in;
  assign rsrc[`CII_RSRC_CIPHER] = cipher_in;
  assign rsrc[`CII_RSRC_SW]     = sw_evt_req;

  // nine radio sources merged onto line 1
  cii_radio_merge u_merge (
    .clk      (clk),
    .rst      (rst),
    .src_evt  (rsrc),
    .flag_clr (radio_flag_clr),
    .flags    (radio_flags),
    .line     (gen_line)
  );

  // line map: 0 radio wake, 1 radio general, rest peripherals
  assign lines = {periph_irq, gen_line, radio_wake_evt};

  // pending sets; the non-maskable input bypasses the enables
  assign pend_set[`CII_NUM_IRQ-1:0] = lines & irq_enable;
  assign pend_set[`CII_CAND_SVC]     = svc_req;
  assign pend_set[`CII_CAND_PENDABLE_SERVICE_EXCEPTION]  = pendable_service_exception_set;
  assign pend_set[`CII_CAND_SYSTICK] = st_fire;
  assign pend_set[`CII_CAND_FAULT]   = fault_req;
  assign pend_set[`CII_CAND_NMI]     = nmi_req;

  // urgency per slot
  genvar g;
  generate
    for (g = 0; g < `CII_NUM_CAND; g = g + 1) begin : g_lvl
      localparam [4:0] SLOT = g;
      assign cand_lvl[g] = cii_level(SLOT, prio[g]);
    end
  endgenerate

  // level of the running handler, idle in thread state
  assign top_i   = sp - 3'h1;
  assign cur_lvl = (sp == 3'h0) ? `CII_LVL_IDLE : stk[top_i];

  // most urgent pending slot; descending scan lets lowest index win ties
  always @* begin
    best_idx = 5'h00;
    best_lvl = `CII_LVL_IDLE;
    best_hit = 1'b0;
    for (i = `CII_NUM_CAND - 1; i >= 0; i = i - 1) begin
      if (pend[i] && (cand_lvl[i] <= best_lvl)) begin
        best_idx = i[4:0];
        best_lvl = cand_lvl[i];
        best_hit = 1'b1;
      end
    end
  end

  // entry starts only for a strictly more urgent request
  assign start_entry = best_hit && (best_lvl < cur_lvl) && !core_asleep
                     && (state != ST_ENTRY);
  assign entry_done  = (state == ST_ENTRY)
                     && (entry_cnt == `CII_ENTRY_CYC - 5'h01);

  // pending bits: a new request beats the clear of the taken slot
  always @* begin
    take_clr = {`CII_NUM_CAND{1'b0}};
    if (entry_done)
      take_clr[win_idx] = 1'b1;
    next_pend = pend_set | (pend & ~take_clr);
  end

  // pending store
  always @(posedge clk) begin
    if (rst)
      pend <= {`CII_NUM_CAND{1'b0}};
    else
      pend <= next_pend;
  end

  // programmable level table
  always @(posedge clk) begin
    if (rst) begin
      for (j = 0; j < `CII_NUM_CAND; j = j + 1)
        prio[j] <= `CII_PRIO_RST;
    end else if (prio_wr && (prio_idx < `CII_NUM_PRIO_SLOTS)) begin
      prio[prio_idx] <= prio_val;
    end
  end

  // thread / entry / handler sequencing with nesting stack
  always @(posedge clk) begin
    if (rst) begin
      state        <= ST_THREAD;
      sp           <= 3'h0;
      win_idx      <= 5'h00;
      win_lvl      <= `CII_LVL_IDLE;
      entry_cnt    <= 5'h00;
      exc_take     <= 1'b0;
      exc_num      <= 6'h00;
      vec_addr     <= 32'h0000_0000;
      handler_mode <= 1'b0;
      active_level <= `CII_LVL_IDLE;
      for (k = 0; k < `CII_STACK_DEPTH; k = k + 1)
        stk[k] <= `CII_LVL_IDLE;
    end else begin
      exc_take     <= 1'b0;
      active_level <= cur_lvl;
      case (state)
        ST_THREAD: begin
          if (start_entry) begin
            win_idx   <= best_idx;
            win_lvl   <= best_lvl;
            entry_cnt <= 5'h00;
            state     <= ST_ENTRY;
          end
        end
        ST_ENTRY: begin
          entry_cnt <= entry_cnt + 5'h01;
          if (entry_done) begin
            stk[sp]      <= win_lvl;
            sp           <= sp + 3'h1;
            exc_take     <= 1'b1;
            exc_num      <= cii_excnum(win_idx);
            vec_addr     <= vtor_base + {24'h00_0000, cii_excnum(win_idx), 2'h0};
            handler_mode <= 1'b1;
            state        <= ST_HANDLER;
          end
        end
        ST_HANDLER: begin
          // a return beats a same-cycle preemption; the request re-arbitrates next
          if (exc_return) begin
            sp <= top_i;
            if (sp == 3'h1) begin
              handler_mode <= 1'b0;
              state        <= ST_THREAD;
            end
          end else if (start_entry) begin
            win_idx   <= best_idx;
            win_lvl   <= best_lvl;
            entry_cnt <= 5'h00;
            state     <= ST_ENTRY;
          end
        end
        default: begin
          state <= ST_THREAD;
        end
      endcase
    end
  end

  // wake-up detector: runs while asleep, wakes on any pending source
  always @(posedge clk) begin
    if (rst) begin
      core_asleep <= 1'b0;
      wake_pulse  <= 1'b0;
    end else begin
      wake_pulse <= 1'b0;
      if (core_asleep && best_hit) begin
        core_asleep <= 1'b0;
        wake_pulse  <= 1'b1;
      end else if (sleep_enter && !best_hit) begin
        core_asleep <= 1'b1;
      end
    end
  end

  // system tick down counter, fires on reaching zero
  assign st_fire = systick_en && (systick_val == 24'h00_0001);

  // reload on zero, else count down
  always @(posedge clk) begin
    if (rst)
      systick_val <= 24'h00_0000;
    else if (systick_en) begin
      if (systick_val == 24'h00_0000)
        systick_val <= systick_reload;
      else
        systick_val <= systick_val - 24'h00_0001;
    end
  end

  // base time reference divider and radio time in base ticks
  always @(posedge clk) begin
    if (rst) begin
      tick_div   <= {`CII_TICKDIV_W{1'b0}};
      base_tick  <= 1'b0;
      radio_time <= 16'h0000;
    end else begin
      base_tick <= 1'b0;
      if ({15'h0000, tick_div} == BASE_TICK_CYC - 1) begin
        tick_div  <= {`CII_TICKDIV_W{1'b0}};
        base_tick <= 1'b1;
      end else begin
        tick_div <= tick_div + 17'h0_0001;
      end
      if (base_tick)
        radio_time <= radio_time + 16'h0001;
    end
  end

endmodule

// ===== cii_defines.vh
// constants for the processor interrupt intake block
`ifndef CII_DEFINES_VH
`define CII_DEFINES_VH

// interrupt lines and candidate slots
`define CII_NUM_IRQ        24
`define CII_NUM_CAND       29
`define CII_LINE_WAKE      0
`define CII_LINE_GEN       1
`define CII_CAND_SVC       5'h18
`define CII_CAND_PENDABLE_SERVICE_EXCEPTION    5'h19
`define CII_CAND_SYSTICK   5'h1a
`define CII_CAND_FAULT     5'h1b
`define CII_CAND_NMI       5'h1c
`define CII_NUM_PRIO_SLOTS 5'h1b

// exception numbers
`define CII_EXC_NMI        6'h02
`define CII_EXC_FAULT      6'h03
`define CII_EXC_SVC        6'h0b
`define CII_EXC_PENDABLE_SERVICE_EXCEPTION     6'h0e
`define CII_EXC_SYSTICK    6'h0f
`define CII_EXC_IRQ_BASE   6'h10

// urgency levels, lower is more urgent
`define CII_LVL_NMI        3'h0
`define CII_LVL_FAULT      3'h1
`define CII_LVL_PROG_BASE  3'h2
`define CII_LVL_IDLE       3'h7

// timing
`define CII_CLK_PERIOD_NS  10
`define CII_BASE_TICK_NS   625000
`define CII_ENTRY_CYC      5'h10
`define CII_GROSS_SHIFT    4
`define CII_TICKDIV_W      17

// widths and reset values
`define CII_PRIO_W         2
`define CII_SYSTICK_W      24
`define CII_RTIME_W        16
`define CII_PRIO_RST       2'h0
`define CII_STACK_DEPTH    8

// radio general sources, bit positions
`define CII_RSRC_NUM       9
`define CII_RSRC_FINE      0
`define CII_RSRC_GROSS     1
`define CII_RSRC_TICK      2
`define CII_RSRC_SLEEP     3
`define CII_RSRC_ERROR     4
`define CII_RSRC_RX        5
`define CII_RSRC_EVTEND    6
`define CII_RSRC_CIPHER    7
`define CII_RSRC_SW        8

`endif

// ===== cii_radio_merge.v
// sticky radio event flags merged onto one interrupt line
`include "cii_defines.vh"

module cii_radio_merge (
  input  wire                      clk,
  input  wire                      rst,
  input  wire [`CII_RSRC_NUM-1:0]  src_evt,
  input  wire [`CII_RSRC_NUM-1:0]  flag_clr,
  output reg  [`CII_RSRC_NUM-1:0]  flags,
  output reg                       line
);

  wire [`CII_RSRC_NUM-1:0] next_flags;

  // per source: an event in the clear cycle wins over the clear
  genvar g;
  generate
    for (g = 0; g < `CII_RSRC_NUM; g = g + 1) begin : g_src
      assign next_flags[g] = src_evt[g] | (flags[g] & ~flag_clr[g]);
    end
  endgenerate

  // flags stay readable one by one, line is their or
  always @(posedge clk) begin
    if (rst) begin
      flags <= {`CII_RSRC_NUM{1'b0}};
      line  <= 1'b0;
    end else begin
      flags <= next_flags;
      line  <= |next_flags;
    end
  end

endmodule

// ===== cii_intake_props.sv
// concurrent checks on the interrupt intake ports
module cii_intake_props (
  input logic        clk,
  input logic        rst,
  input logic        packet_rx_in,
  input logic        systick_en,
  input logic [23:0] systick_reload,
  input logic [31:0] vtor_base,
  input logic        exc_take,
  input logic [5:0]  exc_num,
  input logic [31:0] vec_addr,
  input logic        handler_mode,
  input logic [2:0]  active_level,
  input logic        core_asleep,
  input logic        wake_pulse,
  input logic [8:0]  radio_flags,
  input logic [23:0] systick_val
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // entry always lands in handler state
  take_mode_a:
    assert property (exc_take |-> handler_mode) else $error("entry outside handler state");
  // handler address comes from the table base
  vec_addr_a:
    assert property (exc_take |-> vec_addr == vtor_base + {24'h00_0000, exc_num, 2'h0})
      else $error("wrong handler address");
  // no entry can follow another in under sixteen cycles
  entry_gap_a:
    assert property (exc_take |=> (!exc_take)[*8] ##1 (!exc_take)[*8])
      else $error("entries too close together");
  nmi_level_a:
    assert property (exc_take && exc_num == 6'h02 |=> active_level == 3'h0)
      else $error("non-maskable entry level wrong");
  fault_level_a:
    assert property (exc_take && exc_num == 6'h03 |=> active_level == 3'h1)
      else $error("fault entry level wrong");
  // settled thread state means nothing is running
  thread_idle_a:
    assert property (!handler_mode && !$past(handler_mode) |-> active_level == 3'h7)
      else $error("thread state with a running level");
  wake_src_a:
    assert property (wake_pulse |-> $past(core_asleep)) else $error("wake while awake");
  rx_flag_a:
    assert property (packet_rx_in |=> radio_flags[5]) else $error("receive flag not set");
  tick_reload_a:
    assert property (systick_en && systick_val == 24'h00_0000 |=>
      systick_val == $past(systick_reload)) else $error("tick counter not reloaded");

  // main scenarios seen
  cover property (exc_take && exc_num == 6'h02);
  cover property (exc_take && exc_num == 6'h03);
  cover property (exc_take && exc_num == 6'h0f);
  cover property (wake_pulse);
endmodule

bind cii_intake cii_intake_props cii_intake_props_inst (
  .clk(clk), .rst(rst), .packet_rx_in(packet_rx_in), .systick_en(systick_en),
  .systick_reload(systick_reload), .vtor_base(vtor_base), .exc_take(exc_take),
  .exc_num(exc_num), .vec_addr(vec_addr), .handler_mode(handler_mode),
  .active_level(active_level), .core_asleep(core_asleep), .wake_pulse(wake_pulse),
  .radio_flags(radio_flags), .systick_val(systick_val)
);

// ===== cii_src_model.sv
// partner model: peripheral request levels and radio event strobes
module cii_src_model (
  input  logic        clk,
  input  logic [21:0] set_lines,
  input  logic [5:0]  fire,
  output logic [21:0] periph_irq,
  output logic [5:0]  radio_pulse
);
  timeunit 1ns;
  timeprecision 1ns;

  // sources change just after the falling edge; strobes last one cycle
  always @(negedge clk) begin
    periph_irq <= set_lines;
    radio_pulse <= fire;
  end
endmodule

// ===== tb_cii_intake.sv
// self-checking bench for the interrupt intake block
module tb_cii_intake;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk   = 1'h0;
  logic        rst   = 1'h1;
  logic [6:0]  pv    = 7'h00;
  logic [23:0] en    = 24'h00_0000;
  logic [31:0] vt    = 32'h2000_0100;
  logic [4:0]  pidx  = 5'h00;
  logic [1:0]  pval  = 2'h0;
  logic        sten  = 1'h0;
  logic        ract  = 1'h0;
  logic        wake  = 1'h0;
  logic        farm  = 1'h0;
  logic        garm  = 1'h0;
  logic [8:0]  fclr  = 9'h000;
  logic [21:0] sset  = 22'h00_0000;
  logic [5:0]  sfire = 6'h00;
  wire  [21:0] pirq;
  wire  [5:0]  rp;
  wire         hm;
  wire         tk;
  wire         slp;
  wire  [5:0]  xnum;
  wire  [31:0] vaddr;
  wire  [2:0]  alvl;
  wire  [8:0]  rflags;
  wire         wp;
  wire  [15:0] rtime;
  int          err_total = 0;
  int          checks_done = 0;
  int          lat;

  // short base tick keeps the radio timers quick
  cii_intake #(.BASE_TICK_CYC(8)) cii_intake_inst (
    .clk(clk), .rst(rst), .periph_irq(pirq), .irq_enable(en), .nmi_req(pv[5]),
    .prio_wr(pv[6]), .prio_idx(pidx), .prio_val(pval), .svc_req(pv[0]),
    .pendable_service_exception_set(pv[1]), .fault_req(pv[2]), .exc_return(pv[3]), .vtor_base(vt),
    .sleep_enter(pv[4]), .systick_en(sten), .systick_reload(24'h00_0100),
    .radio_active(ract), .radio_wake_evt(wake), .sleep_end_in(rp[0]),
    .radio_error_in(rp[1]), .packet_rx_in(rp[2]), .event_end_in(rp[3]),
    .cipher_in(rp[4]), .sw_evt_req(rp[5]), .fine_arm(farm), .fine_target(16'h0003),
    .gross_arm(garm), .gross_target(12'h001), .radio_flag_clr(fclr),
    .handler_mode(hm), .exc_take(tk), .exc_num(xnum), .vec_addr(vaddr),
    .active_level(alvl), .core_asleep(slp), .wake_pulse(wp), .radio_flags(rflags),
    .radio_time(rtime), .systick_val()
  );
  cii_src_model cii_src_model_inst (
    .clk(clk), .set_lines(sset), .fire(sfire), .periph_irq(pirq), .radio_pulse(rp)
  );

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one-cycle strobe on the core-side inputs
  task pulse(input logic [6:0] m);
    @(negedge clk);
    pv = m;
    @(negedge clk);
    pv = 7'h00;
  endtask

  task ret;
    pulse(7'h08);
    @(negedge clk);
  endtask

  // one-cycle command to the partner model
  task src(input logic [21:0] s, input logic [5:0] f);
    @(posedge clk);
    sset <= s;
    sfire <= f;
    @(posedge clk);
    sset <= 22'h00_0000;
    sfire <= 6'h00;
  endtask

  // bounded wait for an entry, then check what was entered
  task take(input logic [5:0] n);
    int c;
    c = 0;
    while (tk !== 1'h1 && c < 400) begin
      @(posedge clk);
      #1;
      c++;
    end
    lat = c;
    if (c == 400) begin
      err_total++;
      give_verdict;
    end
    chk(xnum, n);
    chk(vaddr, vt + {n, 2'h0});
    chk(hm, 1'h1);
  endtask

  // radio timers first, while the base time is still small
  task t_tick;
    int c;
    ract = 1'h1;
    farm = 1'h1;
    garm = 1'h1;
    c = 0;
    while (rflags[1] !== 1'h1 && c < 400) begin
      @(negedge clk);
      c++;
    end
    if (c == 400) begin
      err_total++;
      give_verdict;
    end
    chk(rflags[2:0], 3'h7);
    // gross fires at tick sixteen, count has moved on once since
    chk(rtime, 16'h0011);
    ract = 1'h0;
    farm = 1'h0;
    garm = 1'h0;
    fclr = 9'h1ff;
    @(negedge clk);
    fclr = 9'h000;
    repeat (40) @(negedge clk);
    chk(rflags, 9'h000);
  endtask

  // non-maskable entry with nothing enabled
  task t_nmi;
    pulse(7'h20);
    take(6'h02);
    chk(lat, 17);
    @(posedge clk);
    #1;
    chk(alvl, 3'h0);
    ret;
    chk(hm, 1'h0);
  endtask

  // equal level: lower line first; masked line ignored
  task t_line;
    en = 24'hc0_0000;
    src(22'h30_0001, 6'h00);
    take(6'h26);
    ret;
    take(6'h27);
    ret;
    repeat (30) @(negedge clk);
    chk(hm, 1'h0);
  endtask

  // more urgent line preempts, then unwinds
  task t_pre;
    pidx = 5'h05;
    pval = 2'h3;
    pulse(7'h40);
    pidx = 5'h06;
    pval = 2'h0;
    pulse(7'h40);
    en = 24'h00_0060;
    src(22'h00_0008, 6'h00);
    take(6'h15);
    src(22'h00_0010, 6'h00);
    #1;
    chk(alvl, 3'h5);
    take(6'h16);
    @(posedge clk);
    #1;
    chk(alvl, 3'h2);
    ret;
    chk(alvl, 3'h5);
    ret;
    chk(hm, 1'h0);
  endtask

  // every radio strobe sets its own flag and enters via line 1
  task t_radio;
    int k;
    en = 24'h00_0002;
    for (k = 0; k < 6; k++) begin
      src(22'h00_0000, 6'h01 << k);
      repeat (2) @(negedge clk);
      chk(rflags, 9'h001 << (k + 3));
      fclr = 9'h001 << (k + 3);
      @(negedge clk);
      fclr = 9'h000;
      take(6'h11);
      ret;
    end
  endtask

  // core-internal exceptions and the tick timer
  task t_sys;
    pulse(7'h01);
    take(6'h0b);
    ret;
    pulse(7'h02);
    take(6'h0e);
    ret;
    pulse(7'h04);
    take(6'h03);
    ret;
    sten = 1'h1;
    take(6'h0f);
    @(negedge clk);
    sten = 1'h0;
    ret;
  endtask

  // sleep, then radio wake on line 0
  task t_sleep;
    en = 24'h00_0001;
    pulse(7'h10);
    chk(slp, 1'h1);
    wake = 1'h1;
    @(negedge clk);
    wake = 1'h0;
    @(negedge clk);
    chk(wp, 1'h1);
    take(6'h10);
    chk(slp, 1'h0);
    ret;
  endtask

  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'h0;
    chk(alvl, 3'h7);
    t_tick;
    t_nmi;
    t_line;
    t_pre;
    t_radio;
    t_sys;
    t_sleep;
    give_verdict;
  end
endmodule
